// File: port_pkg_and_buffer.sv
// shared constants for the slave port, and its two-entry receive buffer
package port_pkg;
  localparam int DATA_W = 8;
  localparam logic [7:0] END_OF_MESSAGE_CODE = 8'h00;
  localparam logic [7:0] NULL_CODE = 8'h00;
  localparam logic [7:0] TRANSFER_COMMAND = 8'h01;
  localparam logic [7:0] COMMAND_A = 8'h5A;
  localparam logic [7:0] COMMAND_A_ACKNOWLEDGE = 8'h07;
  localparam logic REG_SELECT_DATA = 1'b0;
  localparam logic REG_SELECT_STATUS = 1'b1;
  localparam int HS_BIT = 0;
  localparam logic HS_RESET = 1'b0;
  localparam logic TOKEN_RESET = 1'b0;
  localparam logic [7:0] OE_NONE = 8'h00;
  localparam logic [7:0] OE_ALL = 8'hFF;
  localparam logic [7:0] OE_HS_ONLY = 8'h01;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
endpackage : port_pkg

////////////////////////////////////////////////////////////////////////////////

`timescale 1ns/1ps

module two_entry_buffer (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // filling side
  input wire logic in_valid,
  input wire logic [port_pkg::DATA_W-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [port_pkg::DATA_W-1:0] out_data,
  input wire logic out_ready
);
  logic [port_pkg::DATA_W-1:0] head_r, head_nxt, tail_r, tail_nxt;
  logic head_v_r, head_v_nxt, tail_v_r, tail_v_nxt;
  logic push, pop;

  // ready comes from a flop so the filling side sees no combinational path
  assign in_ready = ~tail_v_r;
  assign out_valid = head_v_r;
  assign out_data = head_r;
  assign push = in_valid & ~tail_v_r;
  assign pop = head_v_r & out_ready;

  always_comb begin
    head_nxt = head_r;
    tail_nxt = tail_r;
    head_v_nxt = head_v_r;
    tail_v_nxt = tail_v_r;
    if (pop) begin
      if (tail_v_r) begin
        head_nxt = tail_r;
        tail_v_nxt = 1'b0;
      end else begin
        head_v_nxt = 1'b0;
      end
    end
    if (push) begin
      if (!head_v_nxt) begin
        head_nxt = in_data;
        head_v_nxt = 1'b1;
      end else begin
        tail_nxt = in_data;
        tail_v_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      head_r <= port_pkg::BYTE_RESET;
      tail_r <= port_pkg::BYTE_RESET;
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      head_v_r <= head_v_nxt;
      tail_v_r <= tail_v_nxt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  full_holds_a: assert property (tail_v_r && !out_ready |=> tail_v_r && head_v_r)
    else $error("buffer dropped a word while stalled");
  push_empty_a: assert property (push && !head_v_r |=> out_valid && out_data == $past(in_data))
    else $error("word pushed into empty buffer not presented");
endmodule : two_entry_buffer

// File: parallel_slave_port.sv
// byte-wide memory-mapped slave port with write-token protocol

`timescale 1ns/1ps

module parallel_slave_port (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // master bus strobes
  input wire logic select_input_line_n,
  input wire logic direction_input_line,
  input wire logic register_select_line,
  // data pins, split into input, output and enable
  input wire logic [7:0] data_bus_lines_in,
  output logic [7:0] data_bus_lines_out,
  output logic [7:0] data_bus_lines_oe,
  output logic interrupt_request_line,
  // bytes received from the master
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // bytes to send: a length beat first, then that many data beats
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // token state
  output logic token_held
);
  typedef enum logic [1:0] {RX_CMD, RX_LEN, RX_DATA, RX_EOM} rx_state_t;
  typedef enum logic [2:0] {TX_CMD, TX_LEN, TX_DATA, TX_EOM, TX_WAIT} tx_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // strobe decode

  logic sel, data_rd, stat_rd, wr;
  logic sel_q, data_rd_q, wr_q;
  logic data_rd_start, data_rd_end, wr_start, wr_end;
  logic buf_in_valid, buf_in_ready;

  assign sel = ~select_input_line_n;
  assign data_rd = sel & direction_input_line
    & (register_select_line == port_pkg::REG_SELECT_DATA);
  assign stat_rd = sel & direction_input_line
    & (register_select_line == port_pkg::REG_SELECT_STATUS);
  assign wr = sel & ~direction_input_line;
  // read starts on select or direction rise
  assign data_rd_start = data_rd & ~data_rd_q;
  // read ends on select or direction fall
  assign data_rd_end = ~data_rd & data_rd_q;
  // held select never starts a write, so toggling applies to reads only
  assign wr_start = wr & ~sel_q;
  assign wr_end = wr_q & ~sel;

  ////////////////////////////////////////////////////////////////////////////////
  // protocol state

  logic token_r, token_nxt;
  logic hs_r, hs_nxt;
  rx_state_t rx_state_r, rx_state_nxt;
  tx_state_t tx_state_r, tx_state_nxt;
  logic [7:0] rx_count_r, rx_count_nxt, tx_count_r, tx_count_nxt;
  logic wr_pend_r, wr_pend_nxt, wr_open_r, wr_open_nxt;
  logic [7:0] wr_byte_r, wr_byte_nxt;
  logic ack_pend_r, ack_pend_nxt;
  logic loaded_r, loaded_nxt;
  logic [7:0] data_byte_r, data_byte_nxt;
  logic tx_ready_r, tx_ready_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] dout_r, dout_nxt, doe_r, doe_nxt;
  logic take, rx_done;

  assign take = tx_valid & tx_ready_r;
  assign buf_in_valid = wr_pend_r & (rx_state_r == RX_DATA);

  always_comb begin
    token_nxt = token_r;
    hs_nxt = hs_r;
    rx_state_nxt = rx_state_r;
    tx_state_nxt = tx_state_r;
    rx_count_nxt = rx_count_r;
    tx_count_nxt = tx_count_r;
    wr_pend_nxt = wr_pend_r;
    wr_open_nxt = wr_open_r;
    wr_byte_nxt = wr_byte_r;
    ack_pend_nxt = ack_pend_r;
    loaded_nxt = loaded_r;
    data_byte_nxt = data_byte_r;
    rx_done = 1'b0;

    // master-to-device bytes, one pending at a time
    if (wr_pend_r) begin
      unique case (rx_state_r)
        RX_CMD: begin
          rx_done = 1'b1;
          if (wr_byte_r == port_pkg::TRANSFER_COMMAND) begin
            rx_state_nxt = RX_LEN;
          end else if (wr_byte_r == port_pkg::COMMAND_A) begin
            ack_pend_nxt = 1'b1;
            rx_state_nxt = RX_EOM;
          end else begin
            rx_state_nxt = RX_EOM;
          end
        end
        RX_LEN: begin
          rx_done = 1'b1;
          // eight-bit length caps the packet at 255
          rx_count_nxt = wr_byte_r;
          rx_state_nxt = (wr_byte_r == port_pkg::BYTE_RESET) ? RX_EOM : RX_DATA;
        end
        RX_DATA: begin
          // stalls here until the buffer takes the byte
          if (buf_in_ready) begin
            rx_done = 1'b1;
            rx_count_nxt = rx_count_r - port_pkg::COUNT_ONE;
            if (rx_count_r == port_pkg::COUNT_ONE) begin
              rx_state_nxt = RX_EOM;
            end
          end
        end
        RX_EOM: begin
          // end byte is consumed, token moves here
          rx_done = 1'b1;
          token_nxt = 1'b1;
          rx_state_nxt = RX_CMD;
        end
      endcase
      if (rx_done) begin
        wr_pend_nxt = 1'b0;
        hs_nxt = 1'b0;
      end
    end
    // writes ignored while the device holds the token
    if (wr_start && !token_r) begin
      wr_open_nxt = 1'b1;
    end
    // pins sampled while selected, as the master may drop data when select rises
    if (wr && wr_open_r && !wr_pend_r) begin
      wr_byte_nxt = data_bus_lines_in;
    end
    // a held select with direction low is a read toggle unless select fell first
    if (wr_end && wr_open_r && !token_r) begin
      wr_pend_nxt = 1'b1;
    end
    if (wr_end) begin
      wr_open_nxt = 1'b0;
    end

    // device-to-master bytes
    if (token_r && !loaded_r) begin
      unique case (tx_state_r)
        TX_CMD: begin
          loaded_nxt = 1'b1;
          if (ack_pend_r) begin
            data_byte_nxt = port_pkg::COMMAND_A_ACKNOWLEDGE;
            tx_state_nxt = TX_EOM;
          // packet opens with the transfer command
          end else if (tx_valid) begin
            data_byte_nxt = port_pkg::TRANSFER_COMMAND;
            tx_state_nxt = TX_LEN;
          // nothing to send, pass by null transfer
          end else begin
            data_byte_nxt = port_pkg::NULL_CODE;
            tx_state_nxt = TX_EOM;
          end
        end
        TX_LEN: begin
          if (take) begin
            loaded_nxt = 1'b1;
            data_byte_nxt = tx_data;
            tx_count_nxt = tx_data;
            tx_state_nxt = (tx_data == port_pkg::BYTE_RESET) ? TX_EOM : TX_DATA;
          end
        end
        TX_DATA: begin
          if (take) begin
            loaded_nxt = 1'b1;
            data_byte_nxt = tx_data;
            tx_count_nxt = tx_count_r - port_pkg::COUNT_ONE;
            if (tx_count_r == port_pkg::COUNT_ONE) begin
              tx_state_nxt = TX_EOM;
            end
          end
        end
        TX_EOM: begin
          loaded_nxt = 1'b1;
          data_byte_nxt = port_pkg::END_OF_MESSAGE_CODE;
          tx_state_nxt = TX_WAIT;
        end
        TX_WAIT: begin
          loaded_nxt = loaded_r;
        end
      endcase
      if (loaded_nxt) begin
        hs_nxt = 1'b0;
      end
    end
    if (data_rd_end && token_r && loaded_r) begin
      loaded_nxt = 1'b0;
      // token alternates back to the master
      if (tx_state_r == TX_WAIT) begin
        token_nxt = 1'b0;
        ack_pend_nxt = 1'b0;
        tx_state_nxt = TX_CMD;
        hs_nxt = 1'b0;
      end
    end
    // data-read start or write start without the token raises the flag; set beats clear
    if (data_rd_start || (wr_start && !token_r)) begin
      hs_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin and stream outputs

  always_comb begin
    dout_nxt = data_byte_r;
    doe_nxt = port_pkg::OE_NONE;
    // status read drives only bit zero
    if (stat_rd) begin
      // flag in the low status bit
      dout_nxt = port_pkg::BYTE_RESET;
      dout_nxt[port_pkg::HS_BIT] = hs_r;
      doe_nxt = port_pkg::OE_HS_ONLY;
    // data driven only by the token holder
    end else if (data_rd && token_r) begin
      // full byte on the data pins
      doe_nxt = port_pkg::OE_ALL;
    end
    // length beat pulled only when the device holds the token
    tx_ready_nxt = token_r & ~loaded_r & ~take
      & ((tx_state_r == TX_LEN) || (tx_state_r == TX_DATA));
    // uplink request while the master owns the token
    irq_nxt = ~token_r & tx_valid;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      // master owns the token after reset
      token_r <= port_pkg::TOKEN_RESET;
      hs_r <= port_pkg::HS_RESET;
      rx_state_r <= RX_CMD;
      tx_state_r <= TX_CMD;
      rx_count_r <= port_pkg::BYTE_RESET;
      tx_count_r <= port_pkg::BYTE_RESET;
      wr_pend_r <= 1'b0;
      wr_open_r <= 1'b0;
      wr_byte_r <= port_pkg::BYTE_RESET;
      ack_pend_r <= 1'b0;
      loaded_r <= 1'b0;
      data_byte_r <= port_pkg::BYTE_RESET;
      tx_ready_r <= 1'b0;
      irq_r <= 1'b0;
      dout_r <= port_pkg::BYTE_RESET;
      doe_r <= port_pkg::OE_NONE;
      sel_q <= 1'b0;
      data_rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      token_r <= token_nxt;
      hs_r <= hs_nxt;
      rx_state_r <= rx_state_nxt;
      tx_state_r <= tx_state_nxt;
      rx_count_r <= rx_count_nxt;
      tx_count_r <= tx_count_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_open_r <= wr_open_nxt;
      wr_byte_r <= wr_byte_nxt;
      ack_pend_r <= ack_pend_nxt;
      loaded_r <= loaded_nxt;
      data_byte_r <= data_byte_nxt;
      tx_ready_r <= tx_ready_nxt;
      irq_r <= irq_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      sel_q <= sel;
      data_rd_q <= data_rd;
      wr_q <= wr;
    end
  end

  assign data_bus_lines_out = dout_r;
  assign data_bus_lines_oe = doe_r;
  assign interrupt_request_line = irq_r;
  assign tx_ready = tx_ready_r;
  assign token_held = token_r;

  // received payload bytes of the data register
  two_entry_buffer rx_buf (
    .clock(clock),
    .srst(srst),
    .in_valid(buf_in_valid),
    .in_data(wr_byte_r),
    .in_ready(buf_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence rd_open_s;
    data_rd_start && token_r && loaded_r;
  endsequence
  sequence rd_close_s;
    data_rd_end;
  endsequence

  status_drive_a: assert property (stat_rd |=> doe_r == 8'h01
    && dout_r[0] == $past(hs_r))
    else $error("status read did not drive the flag on bit zero");
  data_drive_a: assert property (data_rd && token_r |=> doe_r == 8'hFF)
    else $error("data read by token holder not driven");
  bus_release_a: assert property (!data_rd && !stat_rd |=> doe_r == 8'h00)
    else $error("bus driven outside a read");
  flag_rise_a: assert property (data_rd_start |=> hs_r)
    else $error("flag not raised at read start");
  write_ignored_a: assert property (wr_end && token_r && !wr_pend_r |=> !wr_pend_r)
    else $error("write accepted while holding the token");
  eom_close_a: assert property (token_r && tx_state_r == TX_WAIT
    |-> data_byte_r == 8'h00)
    else $error("token holder did not end with end-of-message");
  token_handback_a: assert property (rd_open_s ##[1:1000] rd_close_s
    ##0 (tx_state_r == TX_WAIT) |=> !token_r)
    else $error("token not returned after end-of-message read");
  flag_clear_a: assert property (rd_close_s ##0 token_r ##0 (tx_state_r == TX_WAIT)
    |=> !hs_r)
    else $error("flag left high after token handback");
  command_a_ack_a: assert property (wr_pend_r && rx_state_r == RX_CMD
    && wr_byte_r == 8'h5A |=> ack_pend_r && rx_state_r == RX_EOM)
    else $error("command_a not recorded");
  uplink_irq_a: assert property (!token_r && tx_valid |=> interrupt_request_line)
    else $error("interrupt request not raised");
endmodule : parallel_slave_port

// File: master_model.sv
// bus master model standing in for the microprocessor
`timescale 1ns/1ps

module master_model (
  // clock
  input wire logic clock,
  // strobes toward the device
  output logic select_n,
  output logic direction,
  output logic addr_lsb,
  // data pins
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe,
  output logic [7:0] bus_level
);
  logic [7:0] drive_data = 8'h00;
  logic drive_en = 1'b0;
  logic [7:0] last_level = 8'h00;
  logic [7:0] released;

  ////////////////////////////////////////////////////////////////////////////////
  // released pins: bit zero pulled up, the rest show the inverse of last level
  assign released = {~last_level[7:1], 1'b1};
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bus_level[i] = dev_oe[i] ? dev_out[i] : (drive_en ? drive_data[i] : released[i]);
    end
  end
  always @(posedge clock) last_level <= bus_level;

  initial begin
    select_n = 1'b1;
    direction = 1'b1;
    addr_lsb = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one bus cycle
  task automatic access(input logic rs, input logic rnw, input logic toggle,
                        input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge clock);
    #1;
    select_n = 1'b0;
    addr_lsb = rs;
    direction = toggle ? 1'b0 : rnw;
    drive_en = ~rnw;
    drive_data = wdata;
    if (toggle) begin
      @(posedge clock);
      #1;
      direction = 1'b1;
    end
    repeat (3) @(posedge clock);
    #1;
    rdata = bus_level;
    if (toggle) begin
      direction = 1'b0;
      repeat (2) @(posedge clock);
      #1;
    end
    select_n = 1'b1;
    drive_en = 1'b0;
  endtask : access

  task automatic wait_ready(output logic ok);
    logic [7:0] st;
    ok = 1'b0;
    for (int n = 0; n < 400 && !ok; n++) begin
      access(1'b1, 1'b1, 1'b0, 8'h00, st);
      ok = (st[0] === 1'b0);
    end
  endtask : wait_ready
endmodule : master_model

// File: testbench.sv
// self-checking testbench for the parallel slave port
`timescale 1ns/1ps

module testbench;
  logic clock;
  logic srst;
  logic select_n;
  logic direction;
  logic addr_lsb;
  logic [7:0] bus_level;
  logic [7:0] dev_out;
  logic [7:0] oe;
  logic irq;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_ready = 1'b1;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_ready;
  logic token_held;
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  int fails = 0;
  int check_count = 0;

  parallel_slave_port parallel_slave_port_i (
    .clock(clock), .srst(srst), .select_input_line_n(select_n),
    .direction_input_line(direction), .register_select_line(addr_lsb),
    .data_bus_lines_in(bus_level), .data_bus_lines_out(dev_out), .data_bus_lines_oe(oe),
    .interrupt_request_line(irq), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .token_held(token_held)
  );

  master_model master_model_i (
    .clock(clock), .select_n(select_n), .direction(direction), .addr_lsb(addr_lsb),
    .dev_out(dev_out), .dev_oe(oe), .bus_level(bus_level)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stream sides: tx fed from a queue, rx collected while ready
  always @(posedge clock) begin
    if (tx_valid && tx_ready) void'(tx_q.pop_front());
    if (rx_valid && rx_ready) rx_q.push_back(rx_data);
    #1;
    tx_valid = (tx_q.size() > 0);
    tx_data = (tx_q.size() > 0) ? tx_q[0] : 8'h00;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // master sends, an ignored write follows, then the device answer is read
  task automatic exchange(input logic [7:0] wr[$], input logic [7:0] rd[$]);
    logic [7:0] d;
    logic ok;
    foreach (wr[i]) begin
      master_model_i.access(1'b0, 1'b0, 1'b0, wr[i], d);
      master_model_i.wait_ready(ok);
      check("write ready", 8'h01, {7'b0, ok}); // flag returns low
    end
    check("token to device", 8'h01, {7'b0, token_held}); // token handover
    master_model_i.access(1'b0, 1'b0, 1'b0, 8'h77, d); // write refused
    foreach (rd[i]) begin
      master_model_i.access(1'b0, 1'b1, i == 1, 8'h00, d);
      check("read byte", rd[i], d); // data register read
      master_model_i.wait_ready(ok);
      check("read ready", 8'h01, {7'b0, ok}); // flag low before next read
    end
    check("token to master", 8'h00, {7'b0, token_held}); // token alternates
  endtask : exchange

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] d;
    check("token", 8'h00, {7'b0, token_held}); // master owns token
    check("oe idle", 8'h00, oe); // bus released
    check("irq", 8'h00, {7'b0, irq}); // no request
    check("tx_ready", 8'h00, {7'b0, tx_ready}); // idle after reset
    check("rx_valid", 8'h00, {7'b0, rx_valid}); // buffer empty
    fork
      master_model_i.access(1'b1, 1'b1, 1'b0, 8'h00, d);
      begin
        repeat (3) @(posedge clock);
        #2;
        check("status oe", 8'h01, oe); // only bit zero driven
      end
    join
    check("status flag", 8'h00, {7'b0, d[0]}); // flag in bit zero
    fork
      master_model_i.access(1'b0, 1'b1, 1'b0, 8'h00, d);
      begin
        repeat (3) @(posedge clock);
        #2;
        check("data oe", 8'h00, oe); // no drive without token
      end
    join
  endtask : t_reset

  // stalled receiver against the two-entry buffer, device replies with data
  task automatic t_transfer();
    logic [7:0] exp_rx[3] = '{8'hA5, 8'h5A, 8'h07};
    tx_q = '{8'h02, 8'h11, 8'h22};
    rx_ready = 1'b0;
    repeat (3) @(posedge clock);
    #2;
    check("irq", 8'h01, {7'b0, irq}); // uplink request
    fork
      begin
        repeat (200) @(posedge clock);
        #1;
        rx_ready = 1'b1;
      end
      exchange('{8'h01, 8'h03, 8'hA5, 8'h5A, 8'h07, 8'h00},
               '{8'h01, 8'h02, 8'h11, 8'h22, 8'h00}); // packet both ways
    join
    check("rx count", 8'h03, 8'(rx_q.size())); // end code not data
    foreach (exp_rx[i]) check("rx byte", exp_rx[i], rx_q[i]); // payload order
    check("irq", 8'h00, {7'b0, irq}); // request drops
  endtask : t_transfer

  task automatic t_null_command_a();
    exchange('{8'h00, 8'h00}, '{8'h00, 8'h00}); // null transfers
    exchange('{8'h01, 8'h00, 8'h00}, '{8'h00, 8'h00}); // zero length
    exchange('{8'h5A, 8'h00}, '{8'h07, 8'h00}); // command_a answered
    check("rx count", 8'h03, 8'(rx_q.size())); // no stray bytes
  endtask : t_null_command_a

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    srst = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    srst = 1'b0;
    t_reset();
    t_transfer();
    t_null_command_a();
    final_report();
  end

  // hang guard, well above the expected run length
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    final_report();
  end
endmodule : testbench
